/* host_key.sv */
// Host controller model for the power key pin.
// Assumes the bench requests a pulse with GO and LEN, both set on falling edges.
`timescale 1ns/1ps
module host_key (
    input wire logic CLK,
    input wire logic GO,
    input wire logic [31:0] LEN,
    output logic KEY_N
);
    // ----------------------------------------
    // Pulse driver
    // ----------------------------------------
    logic [31:0] left = 32'h0;
    // Moves only on the falling edge, away from the sampling edge
    always @(negedge CLK) begin
        if (GO && left == 32'h0) begin
            left <= LEN;
        end else if (left != 32'h0) begin
            left <= left - 32'h1;
        end
    end
    // Released key goes back to its pull-up level
    assign KEY_N = (left == 32'h0);
endmodule

/* pks_pkg.sv */
// Constants and state types for the power key sequencer.
// Assumes a 125 MHz core clock.
package pks_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned ON_MS = 500;
    localparam int unsigned RESET_MS = 4000;
    localparam int unsigned OFF_MS = 18000;
    localparam int unsigned DEBOUNCE_US = 10;
    localparam int unsigned BOOT_MS = 100;
    localparam int unsigned RESET_HOLD_MS = 10;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1000000;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_PER_US;
    localparam int unsigned CNT_W = 32;

    // ----------------------------------------
    // States
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,
        ST_BOOT,
        ST_RUN,
        ST_RESET,
        ST_SHUT_RESET,
        ST_SHUT_SERIAL
    } state_e;
endpackage

/* pks_props.sv */
// Checker for the power key sequencer outputs.
// Assumes it is bound to every power_key_sequencer instance.
`timescale 1ns/1ps
module pks_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic DOWNLOAD_STRAP_N,
    input wire logic SLEEP_PIN,
    input wire logic SLEEP_CMD,
    input wire logic WAKE_EVENT,
    input wire logic SERIAL_SHUTDOWN_DONE,
    input wire logic CORE_POWER,
    input wire logic CORE_RESET_N,
    input wire logic IO_RAIL_OUTPUT,
    input wire logic SERIAL_READY,
    input wire logic DOWNLOAD_MODE,
    input wire logic SLEEP_MODE
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_boot_start;
        $rose(CORE_POWER);
    endsequence
    sequence s_sleep_asked;
        SERIAL_READY && SLEEP_PIN && SLEEP_CMD && !WAKE_EVENT;
    endsequence
    sequence s_serial_quiet;
        !SERIAL_READY [*8];
    endsequence
    chk_boot_rails: assert property (s_boot_start |-> IO_RAIL_OUTPUT && CORE_RESET_N)
        else $error("rail or reset wrong at power on");
    chk_serial_late: assert property ($rose(IO_RAIL_OUTPUT) |-> s_serial_quiet)
        else $error("serial ready too early");
    chk_rail_drop: assert property ($fell(IO_RAIL_OUTPUT) |-> $past(SERIAL_SHUTDOWN_DONE))
        else $error("rail dropped before serial shutdown");
    chk_rail_with_power: assert property (CORE_POWER |-> IO_RAIL_OUTPUT)
        else $error("powered without rail");
    chk_sleep_cause: assert property (SLEEP_MODE |-> $past(SLEEP_PIN) && $past(SLEEP_CMD))
        else $error("sleep without pin and command");
    chk_sleep_enter: assert property (s_sleep_asked |=> SLEEP_MODE || !SERIAL_READY)
        else $error("sleep not entered");
    chk_wake_prompt: assert property (WAKE_EVENT |=> !SLEEP_MODE)
        else $error("sleep held during wake event");
    chk_reset_hold: assert property ($fell(CORE_RESET_N) |-> (!CORE_RESET_N) [*8])
        else $error("core reset too short");
    chk_dl_enter: assert property ((SERIAL_READY && !DOWNLOAD_STRAP_N) [*4] |=> DOWNLOAD_MODE)
        else $error("download mode not entered");
endmodule
bind power_key_sequencer pks_props chk_u (.CLK(CLK), .RST_N(RST_N),
    .DOWNLOAD_STRAP_N(DOWNLOAD_STRAP_N), .SLEEP_PIN(SLEEP_PIN), .SLEEP_CMD(SLEEP_CMD),
    .WAKE_EVENT(WAKE_EVENT), .SERIAL_SHUTDOWN_DONE(SERIAL_SHUTDOWN_DONE),
    .CORE_POWER(CORE_POWER), .CORE_RESET_N(CORE_RESET_N), .IO_RAIL_OUTPUT(IO_RAIL_OUTPUT),
    .SERIAL_READY(SERIAL_READY), .DOWNLOAD_MODE(DOWNLOAD_MODE), .SLEEP_MODE(SLEEP_MODE));

/* power_key_sequencer.sv */
// Power key sequencer: power on, reset and shutdown from key pulse widths,
// level startup, download strap and sleep gating.
// Assumes pin inputs are asynchronous and commands come from same-clock logic.
`timescale 1ns/1ps
module power_key_sequencer #(
    parameter int unsigned ON_CYC = pks_pkg::ON_MS * pks_pkg::CLK_PER_MS,
    parameter int unsigned RESET_CYC = pks_pkg::RESET_MS * pks_pkg::CLK_PER_MS,
    parameter int unsigned OFF_CYC = pks_pkg::OFF_MS * pks_pkg::CLK_PER_MS,
    parameter int unsigned BOOT_CYC = pks_pkg::BOOT_MS * pks_pkg::CLK_PER_MS,
    parameter int unsigned RESET_HOLD_CYC = pks_pkg::RESET_HOLD_MS * pks_pkg::CLK_PER_MS
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic POWER_KEY_LOW_PULSE_N,
    input wire logic STARTUP_LEVEL_INPUT,
    input wire logic DOWNLOAD_STRAP_N,
    input wire logic SLEEP_PIN,
    input wire logic SLEEP_CMD,
    input wire logic WAKE_EVENT,
    input wire logic SERIAL_SHUTDOWN_DONE,
    output logic CORE_POWER,
    output logic CORE_RESET_N,
    output logic IO_RAIL_OUTPUT,
    output logic SERIAL_READY,
    output logic DOWNLOAD_MODE,
    output logic SLEEP_MODE
);
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic key_low;
    logic startup_hi;
    logic strap_low;
    logic pressed;
    logic [pks_pkg::CNT_W-1:0] low_count;
    pks_pkg::state_e state;
    pks_pkg::state_e next_state;
    logic [pks_pkg::CNT_W-1:0] tmr;
    logic [pks_pkg::CNT_W-1:0] next_tmr;
    logic key_armed;
    logic next_key_armed;
    logic auto_start;
    logic next_auto_start;
    logic next_core_power;
    logic next_core_reset_n;
    logic next_io_rail;
    logic next_serial_ready;
    logic next_download;
    logic next_sleep;
    // Idle pin levels: key up, startup low, strap open, so no false start after reset
    localparam logic [2:0] PIN_IDLE = 3'h5;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync1 <= PIN_IDLE;
            sync2 <= PIN_IDLE;
        end else begin
            sync1 <= {POWER_KEY_LOW_PULSE_N, STARTUP_LEVEL_INPUT, DOWNLOAD_STRAP_N};
            sync2 <= sync1;
        end
    end

    assign key_low = ~sync2[2];
    assign startup_hi = sync2[1];
    assign strap_low = ~sync2[0];

    pulse_timer #(
        .DEBOUNCE(pks_pkg::DEBOUNCE_CYC)
    ) u_timer (
        .CLK(CLK),
        .RST_N(RST_N),
        .KEY_LOW(key_low),
        .PRESSED(pressed),
        .LOW_COUNT(low_count)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Reset and shutdown thresholds act on release, so a 4s press does not reset on its way to 18s.
    // The key must be seen released after each action before it acts again.
    always_comb begin
        next_state = state;
        next_tmr = tmr;
        next_key_armed = key_armed;
        next_auto_start = auto_start;
        next_core_power = CORE_POWER;
        next_core_reset_n = CORE_RESET_N;
        next_io_rail = IO_RAIL_OUTPUT;
        next_serial_ready = SERIAL_READY;
        next_download = DOWNLOAD_MODE;
        next_sleep = SLEEP_MODE;
        if (!pressed) begin
            next_key_armed = 1'b1;
        end
        unique case (state)
            pks_pkg::ST_OFF: begin
                next_core_power = 1'b0;
                next_core_reset_n = 1'b0;
                next_io_rail = 1'b0;
                next_serial_ready = 1'b0;
                next_sleep = 1'b0;
                next_download = 1'b0;
                if (startup_hi) begin
                    next_state = pks_pkg::ST_BOOT;
                    next_auto_start = 1'b1;
                    next_tmr = '0;
                end else if (key_armed && pressed && low_count > ON_CYC) begin
                    next_state = pks_pkg::ST_BOOT;
                    next_key_armed = 1'b0;
                    next_auto_start = 1'b0;
                    next_tmr = '0;
                end
            end
            pks_pkg::ST_BOOT: begin
                next_core_power = 1'b1;
                next_core_reset_n = 1'b1;
                next_io_rail = 1'b1;
                next_serial_ready = 1'b0;
                next_tmr = tmr + 1'b1;
                if (tmr >= BOOT_CYC - 1) begin
                    next_state = pks_pkg::ST_RUN;
                    // RUN reads tmr as a held key length
                    next_tmr = '0;
                end
            end
            pks_pkg::ST_RUN: begin
                next_serial_ready = 1'b1;
                if (startup_hi) begin
                    next_auto_start = 1'b1;
                end
                if (strap_low) begin
                    next_download = 1'b1;
                end
                // Pin and command must agree; any call event wakes at once
                next_sleep = SLEEP_PIN && SLEEP_CMD && !WAKE_EVENT;
                if (key_armed && !pressed && low_count == '0 && tmr > OFF_CYC
                        && !auto_start) begin
                    next_state = pks_pkg::ST_SHUT_RESET;
                    next_tmr = '0;
                    next_sleep = 1'b0;
                end else if (key_armed && !pressed && tmr > RESET_CYC) begin
                    next_state = pks_pkg::ST_RESET;
                    next_tmr = '0;
                    next_sleep = 1'b0;
                end else if (pressed) begin
                    next_tmr = low_count;
                end else begin
                    next_tmr = '0;
                end
            end
            pks_pkg::ST_RESET: begin
                next_core_reset_n = 1'b0;
                next_serial_ready = 1'b0;
                next_download = 1'b0;
                next_tmr = tmr + 1'b1;
                if (tmr >= RESET_HOLD_CYC - 1) begin
                    next_state = pks_pkg::ST_BOOT;
                    next_tmr = '0;
                end
            end
            pks_pkg::ST_SHUT_RESET: begin
                next_core_reset_n = 1'b0;
                next_serial_ready = 1'b0;
                next_tmr = tmr + 1'b1;
                if (tmr >= RESET_HOLD_CYC - 1) begin
                    next_state = pks_pkg::ST_SHUT_SERIAL;
                end
            end
            pks_pkg::ST_SHUT_SERIAL: begin
                next_io_rail = 1'b1;
                if (SERIAL_SHUTDOWN_DONE) begin
                    next_io_rail = 1'b0;
                    next_core_power = 1'b0;
                    next_state = pks_pkg::ST_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= pks_pkg::ST_OFF;
            tmr <= '0;
            key_armed <= 1'b0;
            auto_start <= 1'b0;
            CORE_POWER <= 1'b0;
            CORE_RESET_N <= 1'b0;
            IO_RAIL_OUTPUT <= 1'b0;
            SERIAL_READY <= 1'b0;
            DOWNLOAD_MODE <= 1'b0;
            SLEEP_MODE <= 1'b0;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            key_armed <= next_key_armed;
            auto_start <= next_auto_start;
            CORE_POWER <= next_core_power;
            CORE_RESET_N <= next_core_reset_n;
            IO_RAIL_OUTPUT <= next_io_rail;
            SERIAL_READY <= next_serial_ready;
            DOWNLOAD_MODE <= next_download;
            SLEEP_MODE <= next_sleep;
        end
    end
endmodule

/* power_key_sequencer_bench.sv */
// Self-checking bench for the power key sequencer with shortened counts.
// Assumes host_key models the key and a fixed 1250-cycle debounce.
`timescale 1ns/1ps
module power_key_sequencer_bench;
    // ----------------------------------------
    // Setup
    // ----------------------------------------
    // Thresholds sit above the debounce, which delays both key edges alike
    localparam int unsigned ON = 1300;
    localparam int unsigned RS = 1400;
    localparam int unsigned OFF = 1500;
    localparam int unsigned LAG = 1252;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic startup = 1'b0, strap_n = 1'b1, sleep_pin = 1'b0, sleep_cmd = 1'b0, wake = 1'b0;
    logic done = 1'b0, go = 1'b0, saw = 1'b0, key_n;
    logic [31:0] len = 32'h0;
    logic core_power, core_reset_n, io_rail, serial_ready, dl_mode, sleep_mode;
    int errors = 0, checks_done = 0, i;
    always #4 CLK = ~CLK;
    // Remembers any core reset while powered; set on the rising edge, cleared only by t_reset and t_auto
    always @(posedge CLK) if (core_power === 1'b1 && core_reset_n === 1'b0) saw <= 1'b1;
    host_key host_u (.CLK(CLK), .GO(go), .LEN(len), .KEY_N(key_n));
    power_key_sequencer #(.ON_CYC(ON), .RESET_CYC(RS), .OFF_CYC(OFF), .BOOT_CYC(30),
        .RESET_HOLD_CYC(10)) dut_u (.CLK(CLK), .RST_N(RST_N), .POWER_KEY_LOW_PULSE_N(key_n),
        .STARTUP_LEVEL_INPUT(startup), .DOWNLOAD_STRAP_N(strap_n), .SLEEP_PIN(sleep_pin),
        .SLEEP_CMD(sleep_cmd), .WAKE_EVENT(wake), .SERIAL_SHUTDOWN_DONE(done),
        .CORE_POWER(core_power), .CORE_RESET_N(core_reset_n), .IO_RAIL_OUTPUT(io_rail),
        .SERIAL_READY(serial_ready), .DOWNLOAD_MODE(dl_mode), .SLEEP_MODE(sleep_mode));
    task chk(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask
    task press(input int unsigned n);
        @(negedge CLK);
        go <= 1'b1;
        len <= n;
        @(negedge CLK);
        go <= 1'b0;
    endtask
    task wait_ready;
        for (i = 0; i < 100 && serial_ready !== 1'b1; i++) @(negedge CLK);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_power_on;
        press(ON - 20);
        repeat (2 * LAG + 40) @(negedge CLK);
        chk("short press power", 1'b0, core_power);
        press(ON + 40);
        for (i = 0; i < LAG + ON + 40 && core_power !== 1'b1; i++) @(negedge CLK);
        chk("power delay", 1'b1, i >= LAG + ON - 2 && i <= LAG + ON + 6);
        chk("ready at rail", 1'b0, serial_ready);
        wait_ready();
        chk("ready after boot", 1'b1, serial_ready);
        repeat (2 * LAG) @(negedge CLK);
    endtask
    task t_reset;
        saw = 1'b0;
        press(RS - 20);
        repeat (2 * LAG + RS + 40) @(negedge CLK);
        chk("short press reset", 1'b0, saw);
        press(RS + 20);
        for (i = 0; i < 3000 && core_reset_n !== 1'b0; i++) @(negedge CLK);
        chk("reset asserted", 1'b0, core_reset_n);
        chk("power kept", 1'b1, core_power);
        wait_ready();
        wait_ready();
        chk("ready after reset", 1'b1, serial_ready);
    endtask
    task t_sleep;
        for (int k = 0; k < 8; k++) begin
            @(negedge CLK);
            {sleep_pin, sleep_cmd, wake} = k[2:0];
            @(negedge CLK);
            chk("sleep mode", k[2] & k[1] & ~k[0], sleep_mode);
        end
        {sleep_pin, sleep_cmd, wake} = 3'h0;
    endtask
    task t_download;
        strap_n = 1'b0;
        repeat (6) @(negedge CLK);
        chk("download entry", 1'b1, dl_mode);
        strap_n = 1'b1;
        repeat (6) @(negedge CLK);
        chk("download sticky", 1'b1, dl_mode);
    endtask
    task t_shutdown;
        press(OFF + 20);
        for (i = 0; i < 3000 && core_reset_n !== 1'b0; i++) @(negedge CLK);
        chk("reset before off", 1'b0, core_reset_n);
        repeat (40) @(negedge CLK);
        chk("rail held", 1'b1, io_rail);
        done = 1'b1;
        repeat (3) @(negedge CLK);
        chk("rail off", 1'b0, io_rail);
        chk("power off", 1'b0, core_power);
        chk("download cleared", 1'b0, dl_mode);
        done = 1'b0;
    endtask
    task t_auto;
        startup = 1'b1;
        for (i = 0; i < 10 && core_power !== 1'b1; i++) @(negedge CLK);
        chk("level start", 1'b1, core_power);
        wait_ready();
        saw = 1'b0;
        press(OFF + 20);
        repeat (2 * LAG + OFF + 80) @(negedge CLK);
        chk("auto keeps power", 1'b1, core_power);
        // Shutdown is refused, but the long hold still passes the reset threshold
        chk("auto long press reset", 1'b1, saw);
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge CLK);
        RST_N = 1'b1;
        repeat (20) @(negedge CLK);
        t_power_on();
        t_reset();
        t_sleep();
        t_download();
        t_shutdown();
        t_auto();
        give_verdict();
    end
    // Run needs about 22000 cycles
    initial begin
        repeat (40000) @(posedge CLK);
        errors++;
        give_verdict();
    end
endmodule

/* pulse_timer.sv */
// Debounced low-level duration counter for the power key.
// Assumes the input has already been synchronised to CLK.
`timescale 1ns/1ps
module pulse_timer #(
    parameter int unsigned DEBOUNCE = pks_pkg::DEBOUNCE_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic KEY_LOW,
    output logic PRESSED,
    output logic [pks_pkg::CNT_W-1:0] LOW_COUNT
);
    logic [15:0] stable_cnt;
    logic [15:0] next_stable_cnt;
    logic next_pressed;
    logic [pks_pkg::CNT_W-1:0] next_low_count;

    // ----------------------------------------
    // Debounce and measure
    // ----------------------------------------
    always_comb begin
        next_stable_cnt = stable_cnt;
        next_pressed = PRESSED;
        next_low_count = LOW_COUNT;
        if (KEY_LOW == PRESSED) begin
            next_stable_cnt = 16'h0000;
        end else if (stable_cnt >= 16'(DEBOUNCE - 1)) begin
            next_stable_cnt = 16'h0000;
            next_pressed = KEY_LOW;
        end else begin
            next_stable_cnt = stable_cnt + 16'h0001;
        end
        // Saturate so a stuck key never wraps back under a threshold
        if (!next_pressed) begin
            next_low_count = '0;
        end else if (LOW_COUNT != '1) begin
            next_low_count = LOW_COUNT + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            stable_cnt <= 16'h0000;
            PRESSED <= 1'b0;
            LOW_COUNT <= '0;
        end else begin
            stable_cnt <= next_stable_cnt;
            PRESSED <= next_pressed;
            LOW_COUNT <= next_low_count;
        end
    end
endmodule
